/* logic/smh_device.sv */
/*
  Responding device end of the message handler. Decodes host messages,
  tracks per-host transfer mode, sends completion and save pointer
  messages on command from the controller core, and negotiation on its own.
  Assumes host drives the link through smh_if.host in the pclk domain.
*/
// Design decisions made here: the state encoding and the core command strobe ports.
`timescale 1ns/1ps
module smh_device
  import smh_pkg::*;
(
  smh_if.dev link,
  input wire logic cmd_done,
  input wire logic cmd_linked,
  input wire logic cmd_flag,
  input wire logic cmd_disconnect,
  input wire logic cmd_save_dp,
  input wire logic cmd_reselect,
  input wire logic [1:0] reselect_lun,
  input wire logic [NUM_LUN-1:0] unit_ready,
  output logic [NUM_LUN-1:0] abort_unit,
  output logic clear_all,
  output logic [NUM_LUN-1:0] unit_attention,
  output logic lun_valid,
  output logic [1:0] cur_lun,
  output logic disc_granted,
  output logic sync_mode,
  output logic [7:0] sync_period,
  output logic [7:0] sync_offset
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_SEND = 3'b011,
    ST_FREE = 3'b010
  } smh_dst_t;

  typedef struct packed {
    smh_dst_t st;
    logic [2:0] ext_idx;
    logic [7:0] ext_per;
    logic [SYNC_MSG_BYTES-1:0][7:0] snd;
    logic [2:0] snd_cnt;
    logic [2:0] snd_idx;
    logic free_after;
    logic [NUM_HOST-1:0] host_sync;
    logic [7:0] host_idx;
    logic [NUM_LUN-1:0] abort;
    logic clear;
    logic [NUM_LUN-1:0] attn;
    logic lun_ok;
    logic [1:0] lun;
    logic disc;
    logic [7:0] per;
    logic [7:0] off;
    logic sync;
    logic [7:0] tx;
    logic tx_v;
    logic tx_last;
    logic bfree;
  } smh_dev_t;

  smh_dev_t s_q, s_d;
  logic [7:0] ev_period, ev_offset;
  logic ev_sync;

  smh_sync_eval u_eval (
    .req_period(s_q.ext_per),
    .req_offset(link.i2t_byte),
    .rsp_period(ev_period),
    .rsp_offset(ev_offset),
    .sync_on(ev_sync)
  );

  // Queue a single-byte message for sending
  function automatic smh_dev_t queue1(input smh_dev_t x, input logic [7:0] b, input logic fr);
    smh_dev_t y;
    y = x;
    y.snd[0] = b;
    y.snd_cnt = 3'd1;
    y.snd_idx = 3'd0;
    y.free_after = fr;
    y.st = ST_SEND;
    return y;
  endfunction : queue1

  function automatic smh_dev_t queue_sync(input smh_dev_t x, input logic [7:0] p,
                                          input logic [7:0] o);
    smh_dev_t y;
    y = x;
    y.snd[0] = MSG_EXTENDED;
    y.snd[1] = MSG_SYNC_LEN;
    y.snd[2] = MSG_SYNC_CODE;
    y.snd[3] = p;
    y.snd[4] = o;
    y.snd_cnt = 3'(SYNC_MSG_BYTES);
    y.snd_idx = 3'd0;
    y.free_after = 1'b0;
    y.st = ST_SEND;
    return y;
  endfunction : queue_sync

  // Next-state logic for the whole device end
  always_comb begin
    s_d = s_q;
    s_d.tx_v = 1'b0;
    s_d.tx_last = 1'b0;
    s_d.abort = '0;
    s_d.clear = 1'b0;
    s_d.bfree = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (link.selected) begin
          s_d.host_idx = link.sel_host;
          s_d.lun_ok = 1'b0;
          s_d.st = ST_RECV;
          // Identify rides with the selection strobe; dropping it loses the unit
          if (link.i2t_valid && link.i2t_byte[ID_BIT]) begin
            s_d.lun_ok = (link.i2t_byte[ID_LUN_W-1:0] <= LUN_MAX);
            s_d.lun = link.i2t_byte[1:0];
            s_d.disc = link.i2t_byte[ID_DISC_BIT];
          end
          // Async host gets an offer on every selection
          if (!s_q.host_sync[link.sel_host[2:0]]) begin
            s_d = queue_sync(s_d, PERIOD_MIN, OFFSET_MAX);
          end
        end else if (cmd_reselect) begin
          s_d.lun = reselect_lun;
          s_d.lun_ok = 1'b1;
          s_d = queue1(s_d, {1'b1, 4'h0, 1'b0, reselect_lun}, 1'b0);
        end
      end
      ST_RECV: begin
        if (link.i2t_valid && s_q.ext_idx != 3'd0) begin
          // Walk the extended message body
          s_d.ext_idx = s_q.ext_idx + 3'd1;
          if (s_q.ext_idx == 3'd3) begin
            s_d.ext_per = link.i2t_byte;
          end
          if (s_q.ext_idx == 3'd4) begin
            s_d.ext_idx = 3'd0;
            s_d.per = ev_period;
            s_d.off = ev_offset;
            s_d.sync = ev_sync;
            s_d.host_sync[s_q.host_idx[2:0]] = ev_sync;
            s_d = queue_sync(s_d, ev_period, ev_offset);
          end
        end else if (link.i2t_valid && link.i2t_byte[ID_BIT]) begin
          s_d.lun_ok = (link.i2t_byte[ID_LUN_W-1:0] <= LUN_MAX);
          s_d.lun = link.i2t_byte[1:0];
          s_d.disc = link.i2t_byte[ID_DISC_BIT];
          if (link.i2t_byte[ID_LUN_W-1:0] > LUN_MAX) begin
            s_d = queue1(s_d, MSG_REJECT, 1'b0);
          end
        end else if (link.i2t_valid) begin
          case (link.i2t_byte)
            MSG_EXTENDED: s_d.ext_idx = 3'd1;
            MSG_NOP, MSG_REJECT, MSG_PARITY: begin end
            MSG_INIT_ERR: s_d = queue1(s_d, MSG_RESTORE, 1'b0);
            MSG_ABORT: begin
              if (s_q.lun_ok) begin
                s_d.abort[s_q.lun] = 1'b1;
              end
              s_d.st = ST_FREE;
            end
            MSG_DEV_RESET: begin
              s_d.clear = 1'b1;
              s_d.host_sync = '0;
              s_d.sync = 1'b0;
              s_d.per = '0;
              s_d.off = OFFSET_ASYNC;
              s_d.attn = unit_ready;
              s_d.st = ST_FREE;
            end
            default: s_d = queue1(s_d, MSG_REJECT, 1'b0);
          endcase
        end else if (cmd_done) begin
          if (cmd_linked) begin
            s_d = queue1(s_d, cmd_flag ? MSG_LINKED_FLAG : MSG_LINKED, 1'b0);
          end else begin
            s_d = queue1(s_d, MSG_CMD_DONE, 1'b1);
          end
        end else if (cmd_disconnect && s_q.disc) begin
          s_d = queue1(s_d, MSG_DISCONNECT, 1'b1);
        end else if (cmd_save_dp) begin
          s_d = queue1(s_d, MSG_SAVE_DP, 1'b0);
        end
      end
      ST_SEND: begin
        s_d.tx = s_q.snd[s_q.snd_idx];
        s_d.tx_v = 1'b1;
        s_d.tx_last = (s_q.snd_idx == s_q.snd_cnt - 3'd1);
        s_d.snd_idx = s_q.snd_idx + 3'd1;
        if (s_q.snd_idx == s_q.snd_cnt - 3'd1) begin
          s_d.st = s_q.free_after ? ST_FREE : ST_RECV;
        end
      end
      ST_FREE: begin
        s_d.bfree = 1'b1;
        s_d.lun_ok = 1'b0;
        s_d.ext_idx = 3'd0;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state
  assign link.t2i_byte = s_q.tx;
  assign link.t2i_valid = s_q.tx_v;
  assign link.t2i_last = s_q.tx_last;
  assign link.bus_free = s_q.bfree;
  assign abort_unit = s_q.abort;
  assign clear_all = s_q.clear;
  assign unit_attention = s_q.attn;
  assign lun_valid = s_q.lun_ok;
  assign cur_lun = s_q.lun;
  assign disc_granted = s_q.disc;
  assign sync_mode = s_q.sync;
  assign sync_period = s_q.per;
  assign sync_offset = s_q.off;
endmodule : smh_device

/* common/smh_pkg.sv */
/*
  Shared constants for the message handler pair: message codes, field
  positions, synchronous negotiation limits and the APB register map.
  Assumes both ends and the sync evaluator import it.
*/
package smh_pkg;
  // Message codes
  localparam logic [7:0] MSG_CMD_DONE = 8'h00;
  localparam logic [7:0] MSG_EXTENDED = 8'h01;
  localparam logic [7:0] MSG_SAVE_DP = 8'h02;
  localparam logic [7:0] MSG_RESTORE = 8'h03;
  localparam logic [7:0] MSG_DISCONNECT = 8'h04;
  localparam logic [7:0] MSG_INIT_ERR = 8'h05;
  localparam logic [7:0] MSG_ABORT = 8'h06;
  localparam logic [7:0] MSG_REJECT = 8'h07;
  localparam logic [7:0] MSG_NOP = 8'h08;
  localparam logic [7:0] MSG_PARITY = 8'h09;
  localparam logic [7:0] MSG_LINKED = 8'h0a;
  localparam logic [7:0] MSG_LINKED_FLAG = 8'h0b;
  localparam logic [7:0] MSG_DEV_RESET = 8'h0c;
  localparam logic [7:0] MSG_SYNC_LEN = 8'h03;
  localparam logic [7:0] MSG_SYNC_CODE = 8'h01;
  localparam int SYNC_MSG_BYTES = 5;
  // Identify fields
  localparam int ID_BIT = 7;
  localparam int ID_DISC_BIT = 6;
  localparam int ID_LUN_W = 3;
  localparam logic [2:0] LUN_MAX = 3'h3;
  localparam int NUM_LUN = 4;
  localparam int NUM_HOST = 8;
  // Synchronous negotiation
  localparam int PERIOD_NS_PER_UNIT = 4;
  localparam int CLK_NS = 25;
  localparam logic [7:0] PERIOD_MIN = 8'h3e;
  localparam logic [7:0] PERIOD_TOO_SLOW = 8'h9d;
  localparam logic [7:0] OFFSET_ASYNC = 8'h00;
  localparam logic [7:0] OFFSET_UNLIM = 8'hff;
  localparam logic [7:0] OFFSET_MAX = 8'h08;
  // Host APB register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PTR = 8'h08;
  localparam logic [7:0] REG_SYNC = 8'h0c;
  // Host control bits
  localparam int CTL_SELECT = 0;
  localparam int CTL_DISC_OK = 1;
  localparam int CTL_PAR_ERR = 2;
  localparam int CTL_REJECT = 3;
  localparam int CTL_NEW_CMD = 4;
  localparam int CTL_SEND_ABORT = 5;
  localparam int CTL_SEND_RESET = 6;
  localparam int CTL_SEND_INITERR = 7;
  localparam int CTL_SEND_SYNC = 8;
  localparam int CTL_XFER = 9;
  localparam int CTL_LUN_LSB = 12;
  localparam int CTL_PER_LSB = 16;
  localparam int CTL_OFF_LSB = 24;
endpackage : smh_pkg

/* common/smh_if.sv */
/*
  Message link between the responding device and the host. Bytes move
  with a valid strobe; atn and selected model the host side conditions.
  Assumes a shared pclk and presetn provided by the bench.
*/
`timescale 1ns/1ps
interface smh_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic [7:0] t2i_byte;
  logic t2i_valid;
  logic t2i_last;
  logic [7:0] i2t_byte;
  logic i2t_valid;
  logic i2t_last;
  logic atn;
  logic bus_free;
  logic selected;
  logic [7:0] sel_host;
  modport dev (
    input pclk, presetn, i2t_byte, i2t_valid, i2t_last, atn, selected, sel_host,
    output t2i_byte, t2i_valid, t2i_last, bus_free
  );
  modport host (
    input pclk, presetn, t2i_byte, t2i_valid, t2i_last, bus_free,
    output i2t_byte, i2t_valid, i2t_last, atn, selected, sel_host
  );
endinterface : smh_if

/* logic/smh_sync_eval.sv */
/*
  Evaluates a received synchronous request and forms the reply fields.
  Pure combinational; assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
module smh_sync_eval
  import smh_pkg::*;
(
  input wire logic [7:0] req_period,
  input wire logic [7:0] req_offset,
  output logic [7:0] rsp_period,
  output logic [7:0] rsp_offset,
  output logic sync_on
);
  // Clamp offset and period to what this end can handle
  always_comb begin
    rsp_period = (req_period < PERIOD_MIN) ? PERIOD_MIN : req_period;
    rsp_offset = (req_offset > OFFSET_MAX) ? OFFSET_MAX : req_offset;
    if (req_period >= PERIOD_TOO_SLOW) begin
      rsp_offset = OFFSET_ASYNC;
    end
    sync_on = (rsp_offset != OFFSET_ASYNC);
  end
endmodule : smh_sync_eval

/* logic/smh_host.sv */
/*
  Host end: APB slave for software orders, active and saved pointers,
  and message generation toward the device.
  Assumes the device end sits on the other modport of smh_if.
*/
`timescale 1ns/1ps
module smh_host
  import smh_pkg::*;
(
  smh_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] act_dp;
    logic [NUM_LUN-1:0][7:0] sav_dp;
    logic [7:0] ini_dp;
    logic [1:0] lun;
    logic [7:0] last_rx;
    logic [7:0] tx;
    logic tx_v;
    logic tx_last;
    logic [2:0] sync_idx;
    logic [2:0] rx_ext;
    logic atn;
    logic sel;
    logic [31:0] rd;
    logic rdy;
    logic err;
  } smh_host_t;

  smh_host_t s_q, s_d;
  logic acc;

  assign acc = psel && penable && !s_q.rdy;

  // APB decode, software orders and link receive
  always_comb begin
    s_d = s_q;
    s_d.tx_v = 1'b0;
    s_d.tx_last = 1'b0;
    s_d.sel = 1'b0;
    s_d.rdy = 1'b0;
    s_d.err = 1'b0;
    if (acc) begin
      s_d.rdy = 1'b1;
      case (paddr)
        REG_CTRL: s_d.rd = s_q.ctrl;
        REG_STATUS: s_d.rd = {22'h0, s_q.lun, s_q.last_rx};
        REG_PTR: s_d.rd = {24'h0, s_q.act_dp};
        default: s_d.err = 1'b1;
      endcase
    end
    if (s_q.ctrl[CTL_NEW_CMD]) begin
      s_d.act_dp = '0;
      s_d.sav_dp[s_q.lun] = '0;
      s_d.ctrl[CTL_NEW_CMD] = 1'b0;
    end else if (s_q.ctrl[CTL_XFER]) begin
      s_d.act_dp = s_q.act_dp + 8'h01;
      s_d.ctrl[CTL_XFER] = 1'b0;
    end else if (s_q.ctrl[CTL_SELECT]) begin
      s_d.sel = 1'b1;
      s_d.lun = s_q.ctrl[CTL_LUN_LSB +: 2];
      s_d.tx = {1'b1, s_q.ctrl[CTL_DISC_OK], 3'h0, 1'b0, s_q.ctrl[CTL_LUN_LSB +: 2]};
      s_d.tx_v = 1'b1;
      s_d.tx_last = 1'b1;
      s_d.ctrl[CTL_SELECT] = 1'b0;
    end else if (s_q.ctrl[CTL_SEND_ABORT] || s_q.ctrl[CTL_SEND_RESET] ||
                 s_q.ctrl[CTL_SEND_INITERR]) begin
      s_d.tx = s_q.ctrl[CTL_SEND_ABORT] ? MSG_ABORT :
               s_q.ctrl[CTL_SEND_RESET] ? MSG_DEV_RESET : MSG_INIT_ERR;
      s_d.tx_v = 1'b1;
      s_d.ctrl[CTL_SEND_ABORT] = 1'b0;
      s_d.ctrl[CTL_SEND_RESET] = 1'b0;
      s_d.ctrl[CTL_SEND_INITERR] = 1'b0;
      s_d.tx_last = 1'b1;
    end else if (s_q.ctrl[CTL_SEND_SYNC]) begin
      // Five bytes back to back; the device takes one per cycle
      case (s_q.sync_idx)
        3'd0: s_d.tx = MSG_EXTENDED;
        3'd1: s_d.tx = MSG_SYNC_LEN;
        3'd2: s_d.tx = MSG_SYNC_CODE;
        3'd3: s_d.tx = s_q.ctrl[CTL_PER_LSB +: 8];
        default: s_d.tx = s_q.ctrl[CTL_OFF_LSB +: 8];
      endcase
      s_d.tx_v = 1'b1;
      s_d.sync_idx = s_q.sync_idx + 3'd1;
      if (s_q.sync_idx == 3'(SYNC_MSG_BYTES - 1)) begin
        s_d.tx_last = 1'b1;
        s_d.sync_idx = 3'd0;
        s_d.ctrl[CTL_SEND_SYNC] = 1'b0;
      end
    end
    // Received message handling
    if (link.t2i_valid) begin
      s_d.last_rx = link.t2i_byte;
      if (link.t2i_last && (s_q.ctrl[CTL_PAR_ERR] || s_q.ctrl[CTL_REJECT])) begin
        s_d.atn = 1'b1;
      end
      if (s_q.rx_ext != 3'd0) begin
        // Body bytes of an extended message are data, never codes
        s_d.rx_ext = s_q.rx_ext + 3'd1;
        if (s_q.rx_ext == 3'(SYNC_MSG_BYTES - 1)) begin
          s_d.rx_ext = 3'd0;
        end
      end else if (link.t2i_byte[ID_BIT] && link.t2i_last) begin
        s_d.lun = link.t2i_byte[1:0];
        s_d.act_dp = s_q.sav_dp[link.t2i_byte[1:0]];
      end else begin
        case (link.t2i_byte)
          MSG_SAVE_DP: s_d.sav_dp[s_q.lun] = s_q.act_dp;
          MSG_RESTORE: s_d.act_dp = s_q.sav_dp[s_q.lun];
          MSG_LINKED, MSG_LINKED_FLAG: s_d.act_dp = s_q.ini_dp;
          MSG_DISCONNECT: begin end
          MSG_EXTENDED: s_d.rx_ext = 3'd1;
          default: begin end
        endcase
      end
    end else if (s_q.atn) begin
      s_d.atn = 1'b0;
      s_d.tx = s_q.ctrl[CTL_PAR_ERR] ? MSG_PARITY : MSG_REJECT;
      s_d.tx_v = 1'b1;
      s_d.tx_last = 1'b1;
      s_d.ctrl[CTL_PAR_ERR] = 1'b0;
      s_d.ctrl[CTL_REJECT] = 1'b0;
    end
    // Write lands on the pready edge; a new order beats a bit clearing
    if (psel && penable && pwrite && s_q.rdy && paddr == REG_CTRL) begin
      s_d.ctrl = pwdata;
    end
  end

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.i2t_byte = s_q.tx;
  assign link.i2t_valid = s_q.tx_v;
  assign link.i2t_last = s_q.tx_last;
  assign link.atn = s_q.atn;
  assign link.selected = s_q.sel;
  assign link.sel_host = 8'h00;
  assign prdata = s_q.rd;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
endmodule : smh_host

/* testbench/smh_link_assertions.sv */
/*
  Link checker for the message handler pair: ties device replies and bus
  releases to the bytes that caused them.
  Assumes one pclk domain; the bench top instantiates it beside the link.
*/
`timescale 1ns/1ps
module smh_link_assertions
  import smh_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] t2i_byte,
  input wire logic t2i_valid,
  input wire logic t2i_last,
  input wire logic [7:0] i2t_byte,
  input wire logic i2t_valid,
  input wire logic bus_free
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic t_prev_q;
  logic i_prev_q;
  logic [7:0] i_byte_q;
  // Previous cycle of both streams; a valid byte after an idle one starts a message
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_prev_q <= 1'b0;
      i_prev_q <= 1'b0;
      i_byte_q <= 8'h00;
    end else begin
      t_prev_q <= t2i_valid;
      i_prev_q <= i2t_valid;
      i_byte_q <= i2t_byte;
    end
  end
  property p_done;
    t2i_valid && !t_prev_q && t2i_byte == MSG_CMD_DONE |=> bus_free;
  endproperty
  a_done: assert property (p_done) else $error("no release after completion");
  property p_disc;
    t2i_valid && !t_prev_q && t2i_byte == MSG_DISCONNECT |=> bus_free;
  endproperty
  a_disc: assert property (p_disc) else $error("no release after disconnect");
  property p_abort;
    i2t_valid && !i_prev_q && i2t_byte == MSG_ABORT |-> ##[1:8] bus_free;
  endproperty
  a_abort: assert property (p_abort) else $error("no release after abort");
  property p_reset;
    i2t_valid && !i_prev_q && i2t_byte == MSG_DEV_RESET |-> ##[1:8] bus_free;
  endproperty
  a_reset: assert property (p_reset) else $error("no release after reset");
  // Single-byte codes outside the table must draw a reject
  property p_rej;
    i2t_valid && !i_prev_q && !i2t_byte[7] && i2t_byte > MSG_DEV_RESET
      |-> ##[1:3] t2i_valid && t2i_byte == MSG_REJECT;
  endproperty
  a_rej: assert property (p_rej) else $error("unknown code not rejected");
  property p_sync;
    t2i_valid && !t_prev_q && t2i_byte == MSG_EXTENDED
      |=> t2i_valid && t2i_byte == MSG_SYNC_LEN ##1 t2i_valid && t2i_byte == MSG_SYNC_CODE
      ##1 t2i_valid ##1 t2i_valid && t2i_last;
  endproperty
  a_sync: assert property (p_sync) else $error("bad extended message layout");
  property p_off;
    t2i_valid && !t_prev_q && t2i_byte == MSG_EXTENDED |-> ##4 t2i_byte <= OFFSET_MAX;
  endproperty
  a_off: assert property (p_off) else $error("offset above device limit");
  // Too slow a period must end in an offset of zero
  property p_slow;
    i2t_valid && i_prev_q && i_byte_q == MSG_SYNC_LEN && i2t_byte == MSG_SYNC_CODE
      ##1 i2t_valid && i2t_byte >= PERIOD_TOO_SLOW ##1 i2t_valid
      |-> ##[1:8] t2i_valid && t2i_last && t2i_byte == OFFSET_ASYNC;
  endproperty
  a_slow: assert property (p_slow) else $error("slow period not refused");
  property p_ident;
    t2i_valid && !t_prev_q && t2i_byte[7] |-> t2i_byte[6:2] == 5'h00;
  endproperty
  a_ident: assert property (p_ident) else $error("device identify badly formed");
endmodule : smh_link_assertions

/* testbench/test_scsi_message_handler.sv */
/*
  Bench for the message handler pair: host end ordered over APB, device
  end driven by core strobes, link traffic recorded in between.
  Assumes package, interface and both ends are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_scsi_message_handler
  import smh_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, clear_all, lun_valid, disc_granted, sync_mode;
  logic [7:0] paddr, sync_period, sync_offset;
  logic [31:0] pwdata, prdata;
  logic [5:0] cmd;
  logic [1:0] rs_lun, cur_lun;
  logic [3:0] ready, abort_unit, attn, ab_acc;
  logic [7:0] tq[$], iq[$];
  int bad_count = 0, n_tests = 0, bf_n = 0, clr_n = 0;
  smh_if link (.pclk(pclk), .presetn(presetn));
  smh_device smh_device_inst (.link(link.dev), .cmd_done(cmd[0]), .cmd_linked(cmd[1]),
    .cmd_flag(cmd[2]), .cmd_disconnect(cmd[3]), .cmd_save_dp(cmd[4]), .cmd_reselect(cmd[5]),
    .reselect_lun(rs_lun), .unit_ready(ready), .abort_unit(abort_unit), .clear_all(clear_all),
    .unit_attention(attn), .lun_valid(lun_valid), .cur_lun(cur_lun),
    .disc_granted(disc_granted), .sync_mode(sync_mode), .sync_period(sync_period),
    .sync_offset(sync_offset));
  smh_host smh_host_inst (.link(link.host), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  smh_link_assertions chk_inst (.pclk(pclk), .presetn(presetn), .t2i_byte(link.t2i_byte),
    .t2i_valid(link.t2i_valid), .t2i_last(link.t2i_last), .i2t_byte(link.i2t_byte),
    .i2t_valid(link.i2t_valid), .bus_free(link.bus_free));
  // 40 MHz clock
  initial forever #12.5 pclk = ~pclk;
  // Record link bytes and one-cycle strobes, which would be missed by polling
  always @(posedge pclk) begin
    if (link.t2i_valid === 1'b1) tq.push_back(link.t2i_byte);
    if (link.i2t_valid === 1'b1) iq.push_back(link.i2t_byte);
    if (link.bus_free === 1'b1) bf_n++;
    if (clear_all === 1'b1) clr_n++;
    ab_acc |= abort_unit;
  end
  task automatic end_sim();
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // APB transfer; the answer is waited for, never assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ctl(input logic [31:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b1, REG_CTRL, v, r, e);
  endtask : ctl
  task automatic rdp(input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, REG_PTR, 32'h0, r, e);
    `CHK(r, x)
  endtask : rdp
  // Bounded wait for link bytes and releases, then let strobes land
  task automatic wq(input int nt, input int ni, input int nb);
    int k;
    k = 0;
    while ((tq.size() < nt || iq.size() < ni || bf_n < nb) && k < 300) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 300) bad_count++;
    repeat (3) @(posedge pclk);
  endtask : wq
  task automatic clr();
    tq.delete();
    iq.delete();
    bf_n = 0;
    clr_n = 0;
    ab_acc = 4'h0;
  endtask : clr
  task automatic pulse(input logic [5:0] m);
    @(posedge pclk);
    cmd <= m;
    @(posedge pclk);
    cmd <= 6'h00;
  endtask : pulse
  // Device sync message; period zero means not judged
  task automatic chk5(input logic [7:0] p, input logic [7:0] o);
    `CHK(tq[0], MSG_EXTENDED)
    `CHK(tq[1], MSG_SYNC_LEN)
    `CHK(tq[2], MSG_SYNC_CODE)
    if (p != 8'h00) `CHK(tq[3], p)
    `CHK(tq[4], o)
  endtask : chk5
  task automatic sel(input logic [31:0] lun);
    clr();
    ctl(32'h3 | (lun << CTL_LUN_LSB));
    wq(0, 1, 0);
  endtask : sel
  task automatic t_sel();
    sel(32'h2);
    wq(5, 1, 0);
    `CHK(iq[0], 8'hc2)
    chk5(8'h3e, 8'h08);
    `CHK(cur_lun, 2'h2)
    `CHK(disc_granted, 1'b1)
  endtask : t_sel
  // Pointer save, then a retry that must restore them
  task automatic t_ptr();
    clr();
    ctl(32'h1 << CTL_NEW_CMD);
    ctl(32'h1 << CTL_XFER);
    ctl(32'h1 << CTL_XFER);
    rdp(32'h2);
    pulse(6'h10);
    wq(1, 0, 0);
    `CHK(tq[0], MSG_SAVE_DP)
    ctl(32'h1 << CTL_XFER);
    rdp(32'h3);
    clr();
    ctl(32'h1 << CTL_SEND_INITERR);
    wq(1, 1, 0);
    `CHK(tq[0], MSG_RESTORE)
    rdp(32'h2);
  endtask : t_ptr
  task automatic t_disc();
    clr();
    pulse(6'h08);
    wq(1, 0, 1);
    `CHK(tq[0], MSG_DISCONNECT)
    `CHK(bf_n, 1)
    rdp(32'h2);
    clr();
    rs_lun <= 2'h1;
    pulse(6'h20);
    wq(1, 0, 0);
    `CHK(tq[0], 8'h81)
    `CHK(cur_lun, 2'h1)
  endtask : t_disc
  task automatic t_msg();
    clr();
    ctl(32'h1 << CTL_REJECT);
    pulse(6'h10);
    wq(1, 1, 0);
    `CHK(iq[0], MSG_REJECT)
    clr();
    ctl(32'h1 << CTL_PAR_ERR);
    pulse(6'h10);
    wq(1, 1, 0);
    `CHK(iq[0], MSG_PARITY)
  endtask : t_msg
  // Host-started negotiation across every band of the reply table
  task automatic t_sync();
    logic [7:0] p[4] = '{8'h9d, 8'h50, 8'h30, 8'h60};
    logic [7:0] o[4] = '{8'h05, 8'h04, 8'h20, 8'h00};
    logic [7:0] rp[4] = '{8'h00, 8'h50, 8'h3e, 8'h60};
    logic [7:0] ro[4] = '{8'h00, 8'h04, 8'h08, 8'h00};
    for (int i = 0; i < 4; i++) begin
      clr();
      ctl((32'h1 << CTL_SEND_SYNC) | (32'(p[i]) << CTL_PER_LSB) | (32'(o[i]) << CTL_OFF_LSB));
      wq(5, 5, 0);
      chk5(rp[i], ro[i]);
      `CHK(sync_mode, ro[i] != 8'h00)
      `CHK(sync_offset, ro[i])
    end
  endtask : t_sync
  task automatic t_cmp();
    logic [5:0] m[3] = '{6'h03, 6'h07, 6'h01};
    logic [7:0] x[3] = '{MSG_LINKED, MSG_LINKED_FLAG, MSG_CMD_DONE};
    for (int i = 0; i < 3; i++) begin
      clr();
      pulse(m[i]);
      wq(1, 0, i / 2);
      `CHK(tq[0], x[i])
      `CHK(bf_n, i / 2)
    end
  endtask : t_cmp
  task automatic t_end();
    logic [31:0] r;
    logic e;
    sel(32'h3);
    clr();
    ctl(32'h1 << CTL_SEND_ABORT);
    wq(0, 1, 1);
    `CHK(iq[0], MSG_ABORT)
    `CHK(ab_acc, 4'h8)
    sel(32'h0);
    clr();
    ctl(32'h1 << CTL_SEND_RESET);
    wq(0, 1, 1);
    `CHK(clr_n, 1)
    `CHK(attn, 4'ha)
    `CHK(sync_mode, 1'b0)
    apb(1'b0, REG_SYNC, 32'h0, r, e);
    `CHK(e, 1'b1)
  endtask : t_end
  // Main sequence; reset held for three cycles first
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmd = 6'h00;
    rs_lun = 2'h0;
    ready = 4'ha;
    ab_acc = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_sel();
    t_ptr();
    t_disc();
    t_msg();
    t_sync();
    t_cmp();
    t_end();
    end_sim();
  end
  // Watchdog well past the few hundred cycles the scenarios need
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end
endmodule : test_scsi_message_handler
